// file: rtl/ccs_regs.sv
// Purpose: Charger configuration registers and read-only state register.
// Assumes: Serial protocol engine supplies one-cycle read and write strobes.
// Notes: Read data is registered one cycle after the read strobe.
`timescale 1ns/1ps
module ccs_regs
   import ccs_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic supply_undervoltage_lockout,
   input ccs_bus_t bus,
   input wire logic die_over_temp,
   input wire logic ppm_limiting,
   input wire logic [3:0] current_ratio,
   input wire logic primary_cell_below,
   input ccs_state_t charger_state,
   output logic [7:0] rdata,
   output logic rvalid,
   output ccs_ctrl_t ctrl,
   output logic thermal_foldback,
   output logic comparator_irq
);
   typedef struct packed {
      logic [7:0] cfg0;
      logic [7:0] cfg1;
      logic [7:0] cfg2;
      logic [7:0] cfg3;
      logic [7:0] rdata;
      logic rvalid;
      logic foldback;
      logic cmp_out;
      logic cmp_prev;
      logic irq;
   } ccs_regs_t;

   ccs_regs_t s_q;
   ccs_regs_t s_d;
   logic timer_tick;
   logic wipe;
   logic [7:0] cfg3_view;

   assign wipe = sys_rst | supply_undervoltage_lockout;

   ccs_timer_pace #(
      .DIV(CCS_TIMER_DIV)
   ) u_pace (
      .clk(clk),
      .sys_rst(wipe),
      .adaptive_timer_enable(s_q.cfg0[CCS_BIT_ADAPT]),
      .current_reduced(s_q.foldback | ppm_limiting),
      .current_ratio(current_ratio),
      .tick(timer_tick)
   );

   always_comb begin
      s_d = s_q;
      s_d.rvalid = 1'b0;
      s_d.irq = 1'b0;
      // Write masks keep read-only positions at their fixed values.
      if (bus.wr) begin
         case (bus.addr)
            CCS_ADDR_CFG0: s_d.cfg0 = bus.wdata;
            CCS_ADDR_CFG1: begin
               s_d.cfg1 = (bus.wdata & CCS_WMASK_CFG1) |
                  (CCS_RST_CFG1 & ~CCS_WMASK_CFG1);
            end
            CCS_ADDR_CFG2: begin
               s_d.cfg2 = (bus.wdata & CCS_WMASK_CFG2) |
                  (CCS_RST_CFG2 & ~CCS_WMASK_CFG2);
            end
            CCS_ADDR_CFG3: begin
               s_d.cfg3 = (bus.wdata & CCS_WMASK_CFG3) | (s_q.cfg3 & ~CCS_WMASK_CFG3);
            end
            default: s_d.cfg0 = s_q.cfg0;
         endcase
      end
      // Thermal foldback only acts while the loop is enabled.
      s_d.foldback = s_q.cfg0[CCS_BIT_THERM] & die_over_temp;
      // A disabled comparator reads as below threshold and raises no interrupt.
      s_d.cmp_out = ~s_q.cfg2[CCS_BIT_CMP_EN] | primary_cell_below;
      s_d.cmp_prev = s_q.cmp_out;
      s_d.irq = s_q.cfg2[CCS_BIT_CMP_EN] & s_q.cmp_out & ~s_q.cmp_prev;
      cfg3_view = {s_q.cfg3[7:1], s_q.cmp_out};
      if (bus.rd) begin
         s_d.rvalid = 1'b1;
         case (bus.addr)
            CCS_ADDR_CFG0: s_d.rdata = s_q.cfg0;
            CCS_ADDR_CFG1: s_d.rdata = s_q.cfg1;
            CCS_ADDR_CFG2: s_d.rdata = s_q.cfg2;
            CCS_ADDR_CFG3: s_d.rdata = cfg3_view;
            CCS_ADDR_STATE: s_d.rdata = charger_state;
            default: s_d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (wipe) begin
         s_q.cfg0 <= CCS_RST_CFG0;
         s_q.cfg1 <= CCS_RST_CFG1;
         s_q.cfg2 <= CCS_RST_CFG2;
         s_q.cfg3 <= CCS_RST_CFG3;
         s_q.rdata <= 8'h00;
         s_q.rvalid <= 1'b0;
         s_q.foldback <= 1'b0;
         s_q.cmp_out <= 1'b1;
         s_q.cmp_prev <= 1'b1;
         s_q.irq <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // Decoded controls fan out straight from register bits to the analog core; timer_tick comes from u_pace instead.
   assign ctrl.input_current = s_q.cfg0[CCS_BIT_INCUR +: 2];
   assign ctrl.input_suspend = &s_q.cfg0[CCS_BIT_INCUR +: 2];
   assign ctrl.thermal_regulation_enable = s_q.cfg0[CCS_BIT_THERM];
   assign ctrl.termination_enable = s_q.cfg0[CCS_BIT_TERM_EN];
   assign ctrl.charger_on = s_q.cfg0[CCS_BIT_CHG_ON];
   assign ctrl.precharge_factor = s_q.cfg1[CCS_BIT_PRE +: 2];
   assign ctrl.charge_scale = s_q.cfg1[CCS_BIT_SCALE +: 2];
   assign ctrl.finish_current_factor = s_q.cfg1[CCS_BIT_FINISH +: 2];
   assign ctrl.safety_time_select = s_q.cfg2[CCS_BIT_SAFETY +: 2];
   assign ctrl.precharge_time_select = s_q.cfg2[CCS_BIT_PRETIME];
   assign ctrl.thermistor_select = s_q.cfg2[CCS_BIT_NTC];
   assign ctrl.power_path_threshold_select = s_q.cfg2[CCS_BIT_PPM];
   assign ctrl.comparator_enable = s_q.cfg2[CCS_BIT_CMP_EN];
   assign ctrl.charge_voltage_select = s_q.cfg3[CCS_BIT_VOLT +: 3];
   assign ctrl.temperature_window_shift = s_q.cfg3[CCS_BIT_TSHIFT +: 2];
   assign ctrl.primary_cell_threshold = s_q.cfg3[CCS_BIT_PCELL +: 2];
   assign ctrl.timer_tick = timer_tick;
   assign rdata = s_q.rdata;
   assign rvalid = s_q.rvalid;
   assign thermal_foldback = s_q.foldback;
   assign comparator_irq = s_q.irq;
endmodule

// file: rtl/ccs_pkg.sv
// Purpose: Constants and types for the charger configuration and state register bank.
// Assumes: One 20 MHz clock, synchronous active-high reset, byte-wide register port.
// Notes: Register index is the printed byte address of the serial register map.
package ccs_pkg;
   localparam logic [7:0] CCS_ADDR_CFG0 = 8'h02;
   localparam logic [7:0] CCS_ADDR_CFG1 = 8'h03;
   localparam logic [7:0] CCS_ADDR_CFG2 = 8'h04;
   localparam logic [7:0] CCS_ADDR_CFG3 = 8'h05;
   localparam logic [7:0] CCS_ADDR_STATE = 8'h06;
   localparam logic [7:0] CCS_RST_CFG0 = 8'h6F;
   localparam logic [7:0] CCS_RST_CFG1 = 8'h54;
   localparam logic [7:0] CCS_RST_CFG2 = 8'h4C;
   localparam logic [7:0] CCS_RST_CFG3 = 8'h41;
   localparam logic [7:0] CCS_WMASK_CFG0 = 8'hFF;
   localparam logic [7:0] CCS_WMASK_CFG1 = 8'hFC;
   localparam logic [7:0] CCS_WMASK_CFG2 = 8'hEE;
   localparam logic [7:0] CCS_WMASK_CFG3 = 8'hFE;
   localparam int CCS_BIT_CHG_ON = 0;
   localparam int CCS_BIT_TERM_EN = 1;
   localparam int CCS_BIT_ADAPT = 2;
   localparam int CCS_BIT_THERM = 3;
   localparam int CCS_BIT_INCUR = 4;
   localparam int CCS_BIT_FINISH = 2;
   localparam int CCS_BIT_SCALE = 4;
   localparam int CCS_BIT_PRE = 6;
   localparam int CCS_BIT_CMP_EN = 1;
   localparam int CCS_BIT_PPM = 2;
   localparam int CCS_BIT_NTC = 3;
   localparam int CCS_BIT_PRETIME = 5;
   localparam int CCS_BIT_SAFETY = 6;
   localparam int CCS_BIT_CMP_OUT = 0;
   localparam int CCS_BIT_PCELL = 1;
   localparam int CCS_BIT_TSHIFT = 3;
   localparam int CCS_BIT_VOLT = 5;
   localparam int CCS_TIMER_DIV = 20;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ccs_bus_t;

   typedef struct packed {
      logic [1:0] input_current;
      logic       thermal_regulation_enable;
      logic       termination_enable;
      logic       charger_on;
      logic [1:0] precharge_factor;
      logic [1:0] charge_scale;
      logic [1:0] finish_current_factor;
      logic [1:0] safety_time_select;
      logic       precharge_time_select;
      logic       thermistor_select;
      logic       power_path_threshold_select;
      logic       comparator_enable;
      logic [2:0] charge_voltage_select;
      logic [1:0] temperature_window_shift;
      logic [1:0] primary_cell_threshold;
      logic       input_suspend;
      logic       timer_tick;
   } ccs_ctrl_t;

   typedef struct packed {
      logic state_sleep_flag;
      logic state_reset_flag;
      logic state_idle_flag;
      logic state_precharge_flag;
      logic state_bulk_charge_flag;
      logic state_linear_flag;
      logic state_fault_flag;
      logic state_suspend_flag;
   } ccs_state_t;
endpackage

// file: rtl/ccs_timer_pace.sv
// Purpose: Paces the safety-timer tick, slowing it while charge current is reduced.
// Assumes: Reduction ratio given as a 4-bit code; current is (code + 1) sixteenths of full current.
// Notes: Credit accumulation keeps the average tick rate proportional to current.
`timescale 1ns/1ps
module ccs_timer_pace
   import ccs_pkg::*;
#(
   parameter int DIV = CCS_TIMER_DIV
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic adaptive_timer_enable,
   input wire logic current_reduced,
   input wire logic [3:0] current_ratio,
   output logic tick
);
   typedef struct packed {
      logic [15:0] div_cnt;
      logic [4:0] credit;
      logic tick;
   } ccs_pace_t;
   ccs_pace_t s_q;
   ccs_pace_t s_d;
   logic base_tick;
   logic [5:0] sum;

   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      base_tick = (s_q.div_cnt == 16'(DIV - 1));
      sum = 6'h00;
      s_d.div_cnt = base_tick ? 16'h0000 : s_q.div_cnt + 16'h0001;
      if (base_tick) begin
         // Only a reduced loop with the adaptive mode on slows the timers.
         if (adaptive_timer_enable && current_reduced) begin
            sum = {1'b0, s_q.credit} + {2'h0, current_ratio} + 6'h01;
            if (sum >= 6'h10) begin
               s_d.tick = 1'b1;
               s_d.credit = 5'(sum - 6'h10);
            end else begin
               s_d.credit = sum[4:0];
            end
         end else begin
            s_d.tick = 1'b1;
            s_d.credit = 5'h00;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;
endmodule

// file: sim/ccs_regs_props.sv
// Purpose: Port assertions for the charger register bank.
// Assumes: One clock; lockout acts as a second reset.
// Notes: Base tick period is the fixed 20-cycle default.
`timescale 1ns/1ps
module ccs_regs_chk
   import ccs_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic supply_undervoltage_lockout,
   input ccs_bus_t bus,
   input wire logic die_over_temp,
   input ccs_state_t charger_state,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   input ccs_ctrl_t ctrl,
   input wire logic thermal_foldback,
   input wire logic comparator_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst || supply_undervoltage_lockout);
   a_unmapped_zero: assert property (bus.rd && (bus.addr < 8'h02 || bus.addr > 8'h06)
      |=> rvalid && rdata == 8'h00) else $error("unmapped read not zero");
   a_thermal_fold: assert property (!$past(sys_rst)
      && !$past(supply_undervoltage_lockout)
      |-> thermal_foldback == $past(ctrl.thermal_regulation_enable && die_over_temp))
      else $error("foldback wrong");
   a_charger_on_wr: assert property (bus.wr && bus.addr == 8'h02
      |=> ctrl.charger_on == $past(bus.wdata[0])) else $error("charger enable wrong");
   a_suspend_code: assert property (ctrl.input_suspend == (ctrl.input_current == 2'h3))
      else $error("suspend decode wrong");
   a_cmp_off_one: assert property (!ctrl.comparator_enable [*2] ##0
      (bus.rd && bus.addr == 8'h05) |=> rdata[0]) else $error("comparator bit not 1");
   a_irq_enabled: assert property (comparator_irq
      |-> ctrl.comparator_enable || $past(ctrl.comparator_enable)) else $error("irq disabled");
   a_irq_pulse: assert property (comparator_irq |=> !comparator_irq)
      else $error("irq not a pulse");
   a_ro_bits: assert property (bus.rd && bus.addr == 8'h03 |=> rdata[1:0] == 2'h0)
      else $error("read-only bits set");
   a_state_read: assert property (bus.rd && bus.addr == 8'h06
      |=> rdata == $past(charger_state)) else $error("state read wrong");
   a_tick_spacing: assert property (ctrl.timer_tick |=> !ctrl.timer_tick [*8])
      else $error("ticks too close");
endmodule
bind ccs_regs ccs_regs_chk u_chk (.clk(clk), .sys_rst(sys_rst),
   .supply_undervoltage_lockout(supply_undervoltage_lockout), .bus(bus),
   .die_over_temp(die_over_temp), .charger_state(charger_state), .rdata(rdata),
   .rvalid(rvalid), .ctrl(ctrl), .thermal_foldback(thermal_foldback),
   .comparator_irq(comparator_irq));

// file: sim/ccs_charger_model.sv
// Purpose: Charger core stand-in that reports its current state.
// Assumes: The bench picks the state just after a clock edge.
// Notes: Exactly one flag is raised, so a swapped bit order shows at once.
`timescale 1ns/1ps
module ccs_charger_model
   import ccs_pkg::*;
(
   input wire logic [2:0] state_sel,
   output ccs_state_t charger_state
);
   assign charger_state = ccs_state_t'(8'h01 << state_sel);
endmodule

// file: sim/ccs_regs_bench.sv
// Purpose: Self-checking bench for the charger register bank.
// Assumes: One-cycle strobes, read answer one cycle later, 50 ns clock.
// Notes: Tick pacing is judged at the fixed 20-cycle base period.
`timescale 1ns/1ps
module ccs_regs_bench;
   import ccs_pkg::*;
   logic clk = 1'b0, sys_rst = 1'b1, lockout = 1'b0, hot = 1'b0, ppm = 1'b0, low = 1'b0;
   logic [3:0] ratio = 4'hF;
   logic [2:0] sel = 3'h0;
   logic [7:0] rdata;
   logic rvalid, fold, irq;
   logic [7:0] unm [4] = '{8'h00, 8'h01, 8'h07, 8'hFF};
   ccs_bus_t bus = '0;
   ccs_ctrl_t ctrl;
   ccs_state_t st;
   int error_cnt = 0, checked = 0, cyc = 0, irqs = 0, ticks = 0;
   initial forever #25 clk = ~clk;
   ccs_charger_model u_core (.state_sel(sel), .charger_state(st));
   ccs_regs u_dut (.clk(clk), .sys_rst(sys_rst), .supply_undervoltage_lockout(lockout),
      .bus(bus), .die_over_temp(hot), .ppm_limiting(ppm), .current_ratio(ratio),
      .primary_cell_below(low), .charger_state(st), .rdata(rdata), .rvalid(rvalid),
      .ctrl(ctrl), .thermal_foldback(fold), .comparator_irq(irq));
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (irq === 1'b1) irqs <= irqs + 1;
      if (ctrl.timer_tick === 1'b1) ticks <= ticks + 1;
      if (cyc == 6000) begin
         error_cnt++;
         results();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus = {1'b1, 1'b0, a, d};
      @(posedge clk) #5 bus.wr = 1'b0;
      @(posedge clk) #5;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      bus = {1'b0, 1'b1, a, 8'h00};
      @(posedge clk) #5 bus.rd = 1'b0;
      chk({7'h0, rvalid}, 8'h01);
      chk(rdata, exp);
      @(posedge clk) #5;
   endtask
   // A window of 400 cycles holds a whole number of base periods, so phase cannot matter.
   task automatic pace(input int lo, input int hi);
      int t0;
      t0 = ticks;
      repeat (400) @(posedge clk);
      #5 chk(8'(ticks - t0 >= lo && ticks - t0 <= hi), 8'h01);
   endtask
   task automatic results();
      if (error_cnt == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      #5 sys_rst = 1'b0;
      rd(CCS_ADDR_CFG0, CCS_RST_CFG0);
      rd(CCS_ADDR_CFG1, CCS_RST_CFG1);
      rd(CCS_ADDR_CFG2, CCS_RST_CFG2);
      rd(CCS_ADDR_CFG3, CCS_RST_CFG3);
      foreach (unm[k]) rd(unm[k], 8'h00);
      wr(CCS_ADDR_CFG1, 8'hFF);
      rd(CCS_ADDR_CFG1, 8'hFC);
      wr(CCS_ADDR_CFG2, 8'hFF);
      rd(CCS_ADDR_CFG2, 8'hEE);
      wr(CCS_ADDR_CFG3, 8'hFF);
      rd(CCS_ADDR_CFG3, 8'hFE);
      low = 1'b1;
      repeat (4) @(posedge clk);
      #5 rd(CCS_ADDR_CFG3, 8'hFF);
      chk(8'(irqs), 8'h01);
      wr(CCS_ADDR_CFG2, 8'hEC);
      low = 1'b0;
      repeat (4) @(posedge clk);
      #5 low = 1'b1;
      rd(CCS_ADDR_CFG3, 8'hFF);
      chk(8'(irqs), 8'h01);
      for (int i = 0; i < 8; i++) begin
         wr(CCS_ADDR_CFG0, {2'h1, 2'(i), 1'(i >> 2), 1'b0, 1'(i >> 1), 1'(i)});
         chk({6'h0, ctrl.input_current}, 8'(i % 4));
         chk({7'h0, ctrl.input_suspend}, 8'(i % 4 == 3));
         chk({5'h0, ctrl.thermal_regulation_enable, ctrl.termination_enable, ctrl.charger_on},
            8'(i));
         wr(CCS_ADDR_CFG1, {2'(i), 2'(i), 2'(i), 2'h0});
         chk({ctrl.precharge_factor, ctrl.charge_scale, ctrl.finish_current_factor, 2'h0},
            {2'(i), 2'(i), 2'(i), 2'h0});
         wr(CCS_ADDR_CFG2, {2'(i), 1'(i), 1'b0, 1'(i), 1'(i >> 1), 1'(i >> 2), 1'b0});
         chk({ctrl.safety_time_select, ctrl.precharge_time_select, ctrl.thermistor_select,
            5'h00}, {2'(i), 1'(i), 1'(i), 5'h00});
         chk({6'h00, ctrl.power_path_threshold_select, ctrl.comparator_enable},
            {6'h00, 1'(i >> 1), 1'(i >> 2)});
         wr(CCS_ADDR_CFG3, {3'(i), 2'(i), 2'(i >> 1), 1'b0});
         chk({ctrl.charge_voltage_select, ctrl.temperature_window_shift,
            ctrl.primary_cell_threshold, 1'b0},
            {3'(i), 2'(i), 2'(i >> 1), 1'b0});
      end
      wr(CCS_ADDR_CFG0, 8'h0F);
      hot = 1'b1;
      repeat (2) @(posedge clk);
      #5 chk({7'h0, fold}, 8'h01);
      wr(CCS_ADDR_CFG0, 8'h07);
      chk({7'h0, fold}, 8'h00);
      pace(20, 20);
      ppm = 1'b1;
      ratio = 4'h7;
      pace(9, 11);
      // The thermal loop alone must slow the timers as the power path does.
      ppm = 1'b0;
      wr(CCS_ADDR_CFG0, 8'h0F);
      pace(9, 11);
      wr(CCS_ADDR_CFG0, 8'h03);
      pace(20, 20);
      for (int s = 0; s < 8; s++) begin
         sel = 3'(s);
         rd(CCS_ADDR_STATE, 8'(1 << s));
      end
      wr(CCS_ADDR_CFG1, 8'h00);
      lockout = 1'b1;
      @(posedge clk) #5 lockout = 1'b0;
      rd(CCS_ADDR_CFG1, CCS_RST_CFG1);
      rd(CCS_ADDR_CFG0, CCS_RST_CFG0);
      results();
   end
endmodule
